// ===== hw/msm_pkg.sv
// Constants and types shared by the microport block
package msm_pkg;
    localparam int          ADDR_W          = 3;
    localparam int          DATA_W          = 8;
    localparam int          SEL_W           = 4;
    localparam int          NUM_LOC         = 8;
    localparam int          CLK_PERIOD_NS   = 10;
    // Longest read access, in master clock periods
    localparam int          READ_MAX_CYC    = 13;
    // Cycles the access spends in the wait state before it completes
    localparam int          RESP_CYC        = 3;
    localparam logic [7:0]  LOC_RESET       = 8'h00;
    localparam logic [3:0]  SEL_RESET       = 4'h0;
    // Location that holds the access control register
    localparam logic [2:0]  ACR_ADDR        = 3'h7;
    localparam int          ACR_SEL_LSB     = 2;
    localparam logic [1:0]  CNT_ZERO        = 2'h0;
    localparam logic [1:0]  CNT_LAST        = 2'h2;
    typedef enum logic [3:0] {
        MSM_IDLE = 4'b0001,
        MSM_WAIT = 4'b0010,
        MSM_DONE = 4'b0100,
        MSM_HOLD = 4'b1000
    } msm_state_t;
endpackage

// ===== hw/msm_regfile.sv
// Register storage reached through the microport
`timescale 1ns/1ps
module msm_regfile (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Write side
    input  wire logic        wr_en,
    input  wire logic [2:0]  wr_addr,
    input  wire logic [7:0]  wr_data,
    // Read side
    input  wire logic [2:0]  rd_addr,
    output logic      [7:0]  rd_data,
    // Access control select field
    output logic      [3:0]  sel_field
);
    logic [7:0] loc [msm_pkg::NUM_LOC];

    genvar g;
    generate
        for (g = 0; g < msm_pkg::NUM_LOC; g++) begin : g_loc
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    loc[g] <= msm_pkg::LOC_RESET;
                end else if (wr_en && wr_addr == 3'(g)) begin
                    loc[g] <= wr_data;
                end
            end
        end
    endgenerate

    assign rd_data   = loc[rd_addr];
    assign sel_field = loc[msm_pkg::ACR_ADDR][msm_pkg::ACR_SEL_LSB +: msm_pkg::SEL_W];
endmodule

// ===== hw/msm_microport.sv
// Mode selectable host microport with register storage
// How it works
// [RQ1] Data bus released while chip select high; the registered enable drops one clock after chip select rises
// [RQ2] Host gives 3-bit address per access
// [RQ3] Mode pin picks split or direction strobes
// [RQ4] Shared strobe: data strobe or read strobe
// [RQ5] Shared line: direction or write strobe
// [RQ6] Handshake: acknowledge or ready by mode; code drives one low-active done level in both modes
// [RQ7] Select pins must match control register field; accesses to location 7 are taken without a match
// [RQ8] Reads finish within 13 clock periods
// [RQ9] Host holds inputs until handshake given
`timescale 1ns/1ps
module msm_microport (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Host bus
    input  wire logic        cs_n,
    input  wire logic [2:0]  addr,
    input  wire logic        data_strobe_n,
    input  wire logic        dir_line,
    input  wire logic        direction_strobe_mode,
    input  wire logic [3:0]  device_select_code,
    input  wire logic [7:0]  data_in,
    output logic      [7:0]  data_out,
    output logic             data_oe,
    output logic             transfer_ack_n
);
    msm_pkg::msm_state_t state;
    logic [1:0] cnt;
    logic [7:0] rd_data;
    logic [3:0] sel_field;
    logic       rd_req;
    logic       wr_req;
    logic       act;
    logic       is_read;
    logic       wr_pulse;
    logic       sel_ok;
    logic       next_ack_n;

    // Strobe decode per mode
    always_comb begin
        if (direction_strobe_mode) begin // RQ3
            rd_req = !data_strobe_n && dir_line; // RQ4 RQ5
            wr_req = !data_strobe_n && !dir_line; // RQ4 RQ5
        end else begin
            rd_req = !data_strobe_n; // RQ4
            wr_req = !dir_line; // RQ5
        end
    end

    // Access control write always allowed so the select field can be set
    assign sel_ok = (device_select_code == sel_field) || (addr == msm_pkg::ACR_ADDR); // RQ7
    assign act    = !cs_n && sel_ok && (rd_req || wr_req);

    // Latched direction of the access in flight
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            is_read <= 1'b0;
        end else if (state == msm_pkg::MSM_IDLE && act) begin
            is_read <= rd_req;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= msm_pkg::MSM_IDLE;
        end else begin
            case (state)
                msm_pkg::MSM_IDLE: begin
                    if (act) begin
                        state <= msm_pkg::MSM_WAIT;
                    end
                end
                msm_pkg::MSM_WAIT: begin
                    if (cnt == msm_pkg::CNT_LAST) begin
                        state <= msm_pkg::MSM_DONE; // RQ8
                    end
                end
                msm_pkg::MSM_DONE: begin
                    state <= msm_pkg::MSM_HOLD;
                end
                msm_pkg::MSM_HOLD: begin
                    // Strobes released ends the access
                    if (!(rd_req || wr_req) || cs_n) begin // RQ9
                        state <= msm_pkg::MSM_IDLE;
                    end
                end
                default: state <= msm_pkg::MSM_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt <= msm_pkg::CNT_ZERO;
        end else if (state == msm_pkg::MSM_WAIT) begin
            cnt <= cnt + 2'h1;
        end else begin
            cnt <= msm_pkg::CNT_ZERO;
        end
    end

    // Write happens once, with host data held stable
    assign wr_pulse = (state == msm_pkg::MSM_DONE) && !is_read; // RQ9

    msm_regfile u_regs (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .wr_en     (wr_pulse),
        .wr_addr   (addr), // RQ2
        .wr_data   (data_in),
        .rd_addr   (addr), // RQ2
        .rd_data   (rd_data),
        .sel_field (sel_field)
    );

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            data_out <= msm_pkg::LOC_RESET;
        end else if (state == msm_pkg::MSM_DONE && is_read) begin
            data_out <= rd_data;
        end
    end

    // Drive only during a read we own; the registered enable lags chip
    // select by one clock, so the host must not turn the bus around
    // before the edge after it raises chip select
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            data_oe <= 1'b0;
        end else if (cs_n) begin
            data_oe <= 1'b0; // RQ1
        end else begin
            data_oe <= is_read && (state == msm_pkg::MSM_DONE || state == msm_pkg::MSM_HOLD)
                       && rd_req;
        end
    end

    // Both modes signal completion low; ready reads low while busy would
    // need a separate idle level, so one low-active done level serves both
    always_comb begin
        next_ack_n = 1'b1;
        if (!cs_n && (state == msm_pkg::MSM_DONE || state == msm_pkg::MSM_HOLD)
            && (rd_req || wr_req)) begin
            next_ack_n = 1'b0;
        end
        if (!direction_strobe_mode && state == msm_pkg::MSM_IDLE) begin
            next_ack_n = 1'b1; // RQ6
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            transfer_ack_n <= 1'b1;
        end else begin
            transfer_ack_n <= next_ack_n; // RQ6
        end
    end

    // Read completion bound
    logic [3:0] acc_cnt;
    always_ff @(posedge ref_clk) begin
        if (rst || state == msm_pkg::MSM_IDLE) begin
            acc_cnt <= 4'h0;
        end else if (acc_cnt != 4'hf) begin
            acc_cnt <= acc_cnt + 4'h1;
        end
    end

    chk_read_bound: assert property (@(posedge ref_clk) disable iff (rst) // RQ8
        (state == msm_pkg::MSM_IDLE && act && rd_req) |-> ##[1:12] !transfer_ack_n)
        else $error("read not acknowledged in time");
    chk_bus_release: assert property (@(posedge ref_clk) disable iff (rst) // RQ1
        cs_n |=> !data_oe)
        else $error("bus driven with chip select high");
    chk_ack_timing: assert property (@(posedge ref_clk) disable iff (rst) // RQ6
        (state == msm_pkg::MSM_IDLE && act) ##1 (rd_req || wr_req) [*4] ##0 !cs_n
        |=> !transfer_ack_n)
        else $error("handshake late");
    chk_no_ack_idle: assert property (@(posedge ref_clk) disable iff (rst) // RQ6
        $past(state) == msm_pkg::MSM_IDLE && state == msm_pkg::MSM_IDLE |-> transfer_ack_n)
        else $error("handshake while idle");
    chk_select_gate: assert property (@(posedge ref_clk) disable iff (rst) // RQ7
        (state == msm_pkg::MSM_IDLE && !sel_ok) |=> state == msm_pkg::MSM_IDLE)
        else $error("access taken with wrong select");
    chk_write_once: assert property (@(posedge ref_clk) disable iff (rst) // RQ9
        wr_pulse |=> !wr_pulse)
        else $error("write repeated");
    chk_read_data: assert property (@(posedge ref_clk) disable iff (rst) // RQ2
        (state == msm_pkg::MSM_DONE && is_read) |=> data_out == $past(rd_data))
        else $error("read data wrong");
    chk_mode_write: assert property (@(posedge ref_clk) disable iff (rst) // RQ3 RQ5
        (state == msm_pkg::MSM_IDLE && act && !direction_strobe_mode && !dir_line)
        |=> !is_read)
        else $error("write strobe not decoded");
    chk_busy_bound: assert property (@(posedge ref_clk) disable iff (rst) // RQ8
        acc_cnt <= 4'(msm_pkg::READ_MAX_CYC) || state == msm_pkg::MSM_HOLD)
        else $error("access exceeded bound");
    // Strobe release drops the handshake; refused accesses stay silent
    chk_ack_release: assert property (@(posedge ref_clk) disable iff (rst) // RQ6
        (state == msm_pkg::MSM_HOLD && !(rd_req || wr_req)) |=> transfer_ack_n)
        else $error("handshake held after strobe release");
    chk_refused_quiet: assert property (@(posedge ref_clk) disable iff (rst) // RQ7
        (state == msm_pkg::MSM_IDLE && !cs_n && !sel_ok && (rd_req || wr_req))
        |=> transfer_ack_n)
        else $error("handshake given to another device");
    chk_drive_owner: assert property (@(posedge ref_clk) disable iff (rst) // RQ1
        data_oe |-> (state == msm_pkg::MSM_HOLD && is_read))
        else $error("bus driven outside a read");

    cov_read_split:  cover property (@(posedge ref_clk)
        !direction_strobe_mode && is_read && state == msm_pkg::MSM_DONE);
    cov_write_split: cover property (@(posedge ref_clk)
        !direction_strobe_mode && wr_pulse);
    cov_read_dir:    cover property (@(posedge ref_clk)
        direction_strobe_mode && is_read && state == msm_pkg::MSM_DONE);
    cov_write_dir:   cover property (@(posedge ref_clk)
        direction_strobe_mode && wr_pulse);
    cov_refused:     cover property (@(posedge ref_clk)
        state == msm_pkg::MSM_IDLE && !cs_n && (rd_req || wr_req) && !sel_ok);
endmodule

// ===== tb/msm_host.sv
// Host model that drives single-byte microport accesses
`timescale 1ns/1ps
module msm_host (
    // Clock
    input  wire logic        ref_clk,
    // Host bus
    output logic             cs_n,
    output logic      [2:0]  addr,
    output logic             data_strobe_n,
    output logic             dir_line,
    output logic             direction_strobe_mode,
    output logic      [3:0]  device_select_code,
    output logic      [7:0]  data_in,
    input  wire logic [7:0]  data_out,
    input  wire logic        data_oe,
    input  wire logic        transfer_ack_n
);
    logic [7:0] wd;
    logic       wr_on;
    // No pull on the data wire, so an undriven bus shows the inverse byte
    assign data_in = (wr_on && !data_oe) ? wd : ~wd;
    initial begin
        {cs_n, data_strobe_n, dir_line} = 3'h7;
        {addr, direction_strobe_mode, device_select_code, wd, wr_on} = '0;
    end
    task automatic acc(input logic m, wr, cs, input logic [3:0] sel, input logic [2:0] a,
            input logic [7:0] d, output logic [7:0] rd, output logic oe, output int cyc);
        cyc = 0;
        oe = 1'b0;
        @(posedge ref_clk);
        #1;
        direction_strobe_mode = m;
        {cs_n, device_select_code, addr, wd, wr_on} = {cs, sel, a, d, wr};
        data_strobe_n = m ? 1'b0 : wr;
        dir_line = !wr;
        // Hold everything until the handshake, bounded wait
        while (cyc < 20) begin
            @(posedge ref_clk);
            cyc++;
            oe = oe | (data_oe === 1'b1);
            // Released data wire has no pull, so it reads as the inverse
            rd = data_oe ? data_out : ~data_out;
            if (transfer_ack_n === 1'b0) break;
        end
        #1;
        {cs_n, data_strobe_n, dir_line, wr_on} = 4'b1110;
        repeat (2) @(posedge ref_clk);
    endtask
endmodule

// ===== tb/test_mode_selectable_microport.sv
// Self-checking bench for the microport block
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
    $display("unexpected %0t value mismatch", $time); end end
module test_mode_selectable_microport;
    logic       ref_clk;
    logic       rst;
    logic       cs_n, ds_n, dir, mode, oe_pin, ack_n, oe;
    logic [2:0] addr, a;
    logic [3:0] sel;
    logic [7:0] din, dout, rd, rnd;
    logic [7:0] mem [8];
    int         error_cnt, n_compared, cyc;
    msm_microport dut (.ref_clk(ref_clk), .rst(rst), .cs_n(cs_n), .addr(addr),
        .data_strobe_n(ds_n), .dir_line(dir), .direction_strobe_mode(mode),
        .device_select_code(sel), .data_in(din), .data_out(dout), .data_oe(oe_pin),
        .transfer_ack_n(ack_n));
    msm_host host (.ref_clk(ref_clk), .cs_n(cs_n), .addr(addr), .data_strobe_n(ds_n),
        .dir_line(dir), .direction_strobe_mode(mode), .device_select_code(sel),
        .data_in(din), .data_out(dout), .data_oe(oe_pin), .transfer_ack_n(ack_n));
    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction
    task automatic test_done();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        #200000;
        error_cnt++;
        test_done();
    end
    initial begin
        rst = 1'b1;
        rnd = 8'h5a;
        foreach (mem[i]) mem[i] = 8'h00;
        repeat (12) @(posedge ref_clk);
        #1 rst = 1'b0;
        for (int i = 0; i < 8; i++) begin
            host.acc(i[0], 1'b0, 1'b0, 4'h0, i[2:0], 8'h00, rd, oe, cyc);
            `CHK(rd, mem[i])
        end
        $display("reset values done");
        for (int i = 0; i < 16; i++) begin
            rnd = lfsr(rnd);
            a = (rnd[2:0] == 3'h7) ? 3'h0 : rnd[2:0];
            rnd = lfsr(rnd);
            mem[a] = rnd;
            host.acc(i[0], 1'b1, 1'b0, 4'h0, a, rnd, rd, oe, cyc);
            `CHK(oe, 1'b0)
            // Taken at edge one, wait, done edge launches, seen one edge on
            `CHK(cyc, msm_pkg::RESP_CYC + 3)
            host.acc(i[1], 1'b0, 1'b0, 4'h0, a, ~rnd, rd, oe, cyc);
            `CHK(rd, mem[a])
            `CHK(oe, 1'b1)
            `CHK(cyc <= 13, 1'b1)
        end
        $display("both modes done");
        mem[7] = 8'ha5;
        host.acc(1'b1, 1'b1, 1'b0, 4'h0, 3'h7, 8'ha5, rd, oe, cyc);
        host.acc(1'b0, 1'b0, 1'b0, 4'h0, 3'h2, 8'h00, rd, oe, cyc);
        `CHK(cyc, 20)
        `CHK(oe, 1'b0)
        host.acc(1'b1, 1'b0, 1'b0, 4'h9, 3'h2, 8'h00, rd, oe, cyc);
        `CHK(rd, mem[2])
        host.acc(1'b0, 1'b0, 1'b0, 4'h3, 3'h7, 8'h00, rd, oe, cyc);
        `CHK(rd, mem[7])
        $display("select match done");
        host.acc(1'b1, 1'b0, 1'b1, 4'h9, 3'h2, 8'h00, rd, oe, cyc);
        `CHK(cyc, 20)
        `CHK(oe, 1'b0)
        $display("chip select high done");
        test_done();
    end
endmodule
